//--- uart_8bit_defs.svh
// constants for the 8-bit serial port
`ifndef UART_8BIT_DEFS_SVH
`define UART_8BIT_DEFS_SVH
`define BAUD_DIV_DEFAULT 217
`define DATA_BITS 8
`define FIFO_DEPTH 8
`define BIT_LAST 3'h7
`define SAMPLE_MID_SHIFT 1
`define BAUD_DIV_MIN 4
`endif

//--- uart_8bit_pkg.sv
// package with the state types of the 8-bit serial port
`default_nettype none
package uart_8bit_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_type;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_type;
endpackage
`default_nettype wire

//--- byte_fifo.sv
// small valid/ready fifo for transmit bytes
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, high
  input wire logic inValid, // write offer
  output logic inReady, // space free
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // data present
  input wire logic outReady, // consumer takes
  output logic [WIDTH-1:0] outData // head data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic doWrite, doRead;
  // pointer arithmetic; extra msb separates full from empty
  always_comb begin
    doWrite = inValid && inReady;
    doRead = outValid && outReady;
    next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (doWrite) mem[wrPtr[AW-1:0]] <= inData;
  end
  // status and head, combinational from pointers
  assign inReady = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData = mem[rdPtr[AW-1:0]];
endmodule // byte_fifo
`default_nettype wire

//--- uart_8bit.sv
// 8-bit asynchronous serial port, transmitter and receiver
`include "uart_8bit_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_8bit
  import uart_8bit_pkg::*;
#(
  parameter int BAUD_DIV = `BAUD_DIV_DEFAULT
) (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic reset, // async reset, high
  input wire logic frameLengthSelect, // 0 selects 8-bit frames
  input wire logic rxEnableBit, // receiver enable
  input wire logic multiprocCheckEnable, // require stop bit one
  input wire logic serialIntEnable, // interrupt enable
  input wire logic txWrite, // pulse: write data buffer
  input wire logic [7:0] txWriteData, // byte to send
  output logic txWriteReady, // fifo has room
  input wire logic txDoneClear, // pulse: clear tx done
  input wire logic rxDoneClear, // pulse: clear rx done
  input wire logic serialRxPin, // receive line
  output logic serialTxPin, // transmit line
  output logic [7:0] serialDataBuffer, // received byte
  output logic receivedNinthBit, // stored stop bit
  output logic txDoneFlag, // transmit done
  output logic rxDoneFlag, // receive done
  output logic serialIrq // interrupt request
);
  localparam int CW = $clog2(BAUD_DIV);
  localparam logic [CW-1:0] DIV_LAST = CW'(BAUD_DIV - 1);
  localparam logic [CW-1:0] DIV_HALF = CW'((BAUD_DIV >> `SAMPLE_MID_SHIFT) - 1);
  initial begin
    if (BAUD_DIV < `BAUD_DIV_MIN) $error("baud divider too small");
  end

  // transmit byte queue; writes while full are dropped, txWriteReady flags room a cycle late
  logic fifoValid, fifoTake;
  logic [7:0] fifoData;
  logic fifoInReady;
  byte_fifo #(.WIDTH(`DATA_BITS), .DEPTH(`FIFO_DEPTH)) txQueue (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(txWrite),
    .inReady(fifoInReady),
    .inData(txWriteData),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoData)
  );

  // ---- transmitter state
  tx_state_type txState, next_txState;
  logic [CW-1:0] txCnt, next_txCnt;
  logic [2:0] txBit, next_txBit;
  logic [7:0] txShift, next_txShift;
  logic next_serialTxPin, next_txDoneFlag, txDoneSet;
  // transmit sequencing; 9-bit mode is not served so the port stays idle there
  always_comb begin
    next_txState = txState;
    next_txCnt = txCnt;
    next_txBit = txBit;
    next_txShift = txShift;
    next_serialTxPin = serialTxPin;
    fifoTake = 1'b0;
    txDoneSet = 1'b0;
    unique case (txState)
      TX_IDLE: begin
        next_serialTxPin = 1'b1;
        if (fifoValid && !frameLengthSelect) begin
          fifoTake = 1'b1;
          next_txShift = fifoData;
          next_txCnt = '0;
          next_serialTxPin = 1'b0;
          next_txState = TX_START;
        end
      end
      TX_START, TX_DATA: begin
        if (txCnt == DIV_LAST) begin
          next_txCnt = '0;
          if (txState == TX_START) begin
            next_txBit = '0;
            next_txState = TX_DATA;
          end else begin
            next_txBit = txBit + 3'h1;
            next_txShift = {1'b0, txShift[7:1]};
          end
          if (txState == TX_DATA && txBit == `BIT_LAST) begin
            next_serialTxPin = 1'b1;
            txDoneSet = 1'b1;
            next_txState = TX_STOP;
          end else begin
            next_serialTxPin = (txState == TX_START) ? txShift[0] : txShift[1];
          end
        end else begin
          next_txCnt = txCnt + 1'b1;
        end
      end
      TX_STOP: begin
        if (txCnt == DIV_LAST) begin
          next_txState = TX_IDLE;
        end else begin
          next_txCnt = txCnt + 1'b1;
        end
      end
    endcase
    // set at stop-bit start; set beats clear
    next_txDoneFlag = txDoneSet | (txDoneFlag & ~txDoneClear);
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txState <= TX_IDLE;
      txCnt <= '0;
      txBit <= '0;
      txShift <= '0;
      serialTxPin <= 1'b1;
      txDoneFlag <= 1'b0;
      txWriteReady <= 1'b0;
    end else begin
      txState <= next_txState;
      txCnt <= next_txCnt;
      txBit <= next_txBit;
      txShift <= next_txShift;
      serialTxPin <= next_serialTxPin;
      txDoneFlag <= next_txDoneFlag;
      txWriteReady <= fifoInReady;
    end
  end

  // ---- receiver state, independent of the transmitter
  rx_state_type rxState, next_rxState;
  logic [CW-1:0] rxCnt, next_rxCnt;
  logic [2:0] rxBit, next_rxBit;
  logic [7:0] rxShift, next_rxShift;
  logic [7:0] next_serialDataBuffer;
  logic next_receivedNinthBit, next_rxDoneFlag, rxLoad;
  // receive path has its own state and counter
  always_comb begin
    next_rxState = rxState;
    next_rxCnt = rxCnt;
    next_rxBit = rxBit;
    next_rxShift = rxShift;
    next_serialDataBuffer = serialDataBuffer;
    next_receivedNinthBit = receivedNinthBit;
    rxLoad = 1'b0;
    unique case (rxState)
      RX_IDLE: begin
        if (rxEnableBit && !frameLengthSelect && !serialRxPin) begin
          next_rxCnt = '0;
          next_rxState = RX_START;
        end
      end
      RX_START: begin
        // confirm start at mid-bit so a glitch is ignored
        if (rxCnt == DIV_HALF) begin
          next_rxCnt = '0;
          next_rxBit = '0;
          next_rxState = serialRxPin ? RX_IDLE : RX_DATA;
        end else begin
          next_rxCnt = rxCnt + 1'b1;
        end
      end
      RX_DATA: begin
        if (rxCnt == DIV_LAST) begin
          next_rxCnt = '0;
          next_rxShift = {serialRxPin, rxShift[7:1]};
          next_rxBit = rxBit + 3'h1;
          if (rxBit == `BIT_LAST) next_rxState = RX_STOP;
        end else begin
          next_rxCnt = rxCnt + 1'b1;
        end
      end
      RX_STOP: begin
        if (rxCnt == DIV_LAST) begin
          next_rxState = RX_IDLE;
          // load only when flag clear and stop ok
          if (!rxDoneFlag && (!multiprocCheckEnable || serialRxPin)) begin
            rxLoad = 1'b1;
            next_serialDataBuffer = rxShift;
            next_receivedNinthBit = serialRxPin;
          end
          // otherwise buffer and ninth bit hold
        end else begin
          next_rxCnt = rxCnt + 1'b1;
        end
      end
    endcase
    // software clear; a load in the same cycle wins
    next_rxDoneFlag = rxLoad | (rxDoneFlag & ~rxDoneClear);
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxState <= RX_IDLE;
      rxCnt <= '0;
      rxBit <= '0;
      rxShift <= '0;
      serialDataBuffer <= '0;
      receivedNinthBit <= 1'b0;
      rxDoneFlag <= 1'b0;
      serialIrq <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxCnt <= next_rxCnt;
      rxBit <= next_rxBit;
      rxShift <= next_rxShift;
      serialDataBuffer <= next_serialDataBuffer;
      receivedNinthBit <= next_receivedNinthBit;
      rxDoneFlag <= next_rxDoneFlag;
      serialIrq <= serialIntEnable & (next_txDoneFlag | next_rxDoneFlag);
    end
  end

  // ---- checks
  a_tx_done_stop: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(txDoneFlag) |-> serialTxPin && txState == TX_STOP)
    else $error("tx done not at stop start");
  a_tx_start_low: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == TX_IDLE && fifoValid && !frameLengthSelect) |=> !serialTxPin)
    else $error("start bit missing");
  a_rx_load_cond: assert property (@(posedge clk_sys) disable iff (reset)
    rxLoad |-> !rxDoneFlag)
    else $error("load while rx done set");
  a_rx_load_data: assert property (@(posedge clk_sys) disable iff (reset)
    rxLoad |=> rxDoneFlag && serialDataBuffer == $past(rxShift))
    else $error("load did not store byte");
  a_rx_hold_buf: assert property (@(posedge clk_sys) disable iff (reset)
    !rxLoad |=> $stable(serialDataBuffer) && $stable(receivedNinthBit))
    else $error("buffer changed without load");
  a_rx_disabled: assert property (@(posedge clk_sys) disable iff (reset)
    (rxState == RX_IDLE && !rxEnableBit) |=> rxState == RX_IDLE)
    else $error("receiver started while disabled");
  // request is registered, so it follows the enable of one cycle before
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (reset)
    serialIrq == ($past(serialIntEnable) && (txDoneFlag || rxDoneFlag)))
    else $error("interrupt request wrong");
  a_tx_mode_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == TX_IDLE && frameLengthSelect) |=> txState == TX_IDLE)
    else $error("frame sent in 9-bit mode");
  a_frame_len: assert property (@(posedge clk_sys) disable iff (reset)
    (txState == TX_DATA && txBit == `BIT_LAST && txCnt == DIV_LAST) |=> txState == TX_STOP)
    else $error("frame length wrong");
endmodule // uart_8bit
`default_nettype wire

//--- uart_remote_model.sv
// behavioural remote serial transceiver on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic lineIn, // device transmit line
  output logic lineOut // device receive line
);
  logic [7:0] gotBytes[$];
  logic [7:0] shiftIn;
  // line idles high, as a pulled-up wire would
  initial lineOut = 1'b1;
  task automatic send_frame(input logic [7:0] data, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      lineOut <= frame[i];
      repeat (BIT_CYCLES - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    lineOut <= 1'b1;
  endtask
  always begin
    @(negedge lineIn);
    repeat (BIT_CYCLES / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge clk_sys);
      shiftIn = {lineIn, shiftIn[7:1]};
    end
    repeat (BIT_CYCLES) @(negedge clk_sys);
    // a frame without a stop bit is dropped, so the bench sees it missing
    if (lineIn === 1'b1) gotBytes.push_back(shiftIn);
  end
endmodule // uart_remote_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the 8-bit serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic frameLengthSelect = 1'b0;
  logic rxEnableBit = 1'b1;
  logic multiprocCheckEnable = 1'b0;
  logic serialIntEnable = 1'b1;
  logic txWrite = 1'b0;
  logic [7:0] txWriteData = 8'h00;
  logic txDoneClear = 1'b0;
  logic rxDoneClear = 1'b0;
  logic txWriteReady, serialRxPin, serialTxPin, receivedNinthBit;
  logic txDoneFlag, rxDoneFlag, serialIrq;
  logic [7:0] serialDataBuffer, b;
  logic [7:0] expTx[$];
  logic [9:0] nxt;
  logic [8:0] expStore = 9'h000;
  logic expDone = 1'b0;
  logic stayHigh;
  logic [3:0] cases[6] = '{4'h5, 4'h5, 4'he, 4'h4, 4'h9, 4'hf};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  // short bit time keeps frames to 80 cycles (ten bits of 8 cycles)
  uart_8bit #(.BAUD_DIV(8)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .frameLengthSelect(frameLengthSelect), .rxEnableBit(rxEnableBit),
    .multiprocCheckEnable(multiprocCheckEnable), .serialIntEnable(serialIntEnable),
    .txWrite(txWrite), .txWriteData(txWriteData), .txWriteReady(txWriteReady),
    .txDoneClear(txDoneClear), .rxDoneClear(rxDoneClear), .serialRxPin(serialRxPin),
    .serialTxPin(serialTxPin), .serialDataBuffer(serialDataBuffer),
    .receivedNinthBit(receivedNinthBit), .txDoneFlag(txDoneFlag),
    .rxDoneFlag(rxDoneFlag), .serialIrq(serialIrq));
  uart_remote_model #(.BIT_CYCLES(8)) u_remote (.clk_sys(clk_sys), .lineIn(serialTxPin),
    .lineOut(serialRxPin));
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // gap after each write lets the lagging ready flag catch up
  task automatic write_byte(input logic [7:0] d);
    @(negedge clk_sys);
    txWrite = 1'b1;
    txWriteData = d;
    @(negedge clk_sys);
    txWrite = 1'b0;
    @(negedge clk_sys);
  endtask
  // {loaded, ninth bit, byte} expected when a frame ends
  function automatic logic [9:0] exp_load(logic [7:0] d, logic stopBit);
    if (rxEnableBit && !expDone && (!multiprocCheckEnable || stopBit)) return {2'b11, d} & {1'b1, stopBit, 8'hff};
    return {1'b0, expStore};
  endfunction
  task automatic rx_case(input logic [3:0] c);
    if (c[3]) begin
      rxDoneClear = 1'b1;
      @(negedge clk_sys);
      rxDoneClear = 1'b0;
      expDone = 1'b0;
    end
    {rxEnableBit, multiprocCheckEnable} = c[2:1];
    b = 8'($urandom);
    nxt = exp_load(b, c[0]);
    u_remote.send_frame(b, c[0]);
    repeat (4) @(negedge clk_sys);
    expDone |= nxt[9];
    expStore = nxt[8:0];
    check(serialDataBuffer, expStore[7:0]);
    check({7'h00, receivedNinthBit}, {7'h00, expStore[8]});
    check({7'h00, rxDoneFlag}, {7'h00, expDone});
  endtask
  // main sequence
  initial begin
    void'($urandom(2));
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    check({7'h00, serialTxPin}, 8'h01);
    b = 8'($urandom);
    expTx.push_back(b);
    write_byte(b);
    n = 0;
    while (serialTxPin !== 1'b0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while (txDoneFlag !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(8'(n), 8'd72);
    check({7'h00, serialTxPin}, 8'h01);
    check({7'h00, serialIrq}, 8'h01);
    serialIntEnable = 1'b0;
    @(negedge clk_sys);
    check({7'h00, serialIrq}, 8'h00);
    serialIntEnable = 1'b1;
    txDoneClear = 1'b1;
    @(negedge clk_sys);
    txDoneClear = 1'b0;
    repeat (20) @(negedge clk_sys);
    // nine-bit mode parks bytes in the fifo until it refuses
    frameLengthSelect = 1'b1;
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      expTx.push_back(b);
      write_byte(b);
    end
    check({7'h00, txWriteReady}, 8'h00);
    write_byte(8'h5a);
    stayHigh = 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      stayHigh &= serialTxPin;
    end
    check({7'h00, stayHigh}, 8'h01);
    frameLengthSelect = 1'b0;
    // drain the fifo while frames arrive at the receiver
    fork
      repeat (760) @(negedge clk_sys);
      foreach (cases[i]) rx_case(cases[i]);
    join
    check(8'(u_remote.gotBytes.size()), 8'd9);
    foreach (expTx[i]) check(u_remote.gotBytes[i], expTx[i]);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
